// ---- hw/sib_pkg.sv ----
package sib_pkg;
  // register offsets in the peripheral's register page
  localparam logic [7:0] SIB_OFF_VECTOR = 8'hF4;
  localparam logic [7:0] SIB_OFF_COMPARE = 8'hF5;
  localparam logic [7:0] SIB_OFF_MASK = 8'hF6;
  localparam logic [7:0] SIB_OFF_STATUS = 8'hF7;
  localparam logic [7:0] SIB_OFF_BUFFER = 8'hF8;

  // interrupt_mask fields
  localparam int SIB_M_SRC_SEL = 7;
  localparam int SIB_M_RX_DONE = 6;
  localparam int SIB_M_TX_DONE = 5;
  localparam int SIB_M_ERR = 4;
  localparam int SIB_M_ADDR = 3;
  localparam int SIB_M_BRK = 2;
  localparam int SIB_M_RXD = 1;
  localparam int SIB_M_TXD = 0;

  // interrupt_status fields
  localparam int SIB_S_OVR = 7;
  localparam int SIB_S_FRM = 6;
  localparam int SIB_S_PAR = 5;
  localparam int SIB_S_ADDR = 4;
  localparam int SIB_S_BRK = 3;
  localparam int SIB_S_DATA = 2;
  localparam int SIB_S_BEMP = 1;
  localparam int SIB_S_SEMP = 0;

  // interrupt_vector fields
  localparam int SIB_V_BASE_HI = 7;
  localparam int SIB_V_BASE_LO = 3;
  localparam logic SIB_V_BIT0 = 1'b0;

  // encoded interrupt source
  localparam logic [1:0] SIB_ENC_ERR = 2'h0;
  localparam logic [1:0] SIB_ENC_BRK = 2'h1;
  localparam logic [1:0] SIB_ENC_RXD = 2'h2;
  localparam logic [1:0] SIB_ENC_TX = 2'h3;

  // address mode decode {addr_mode_en, addr_mode}
  localparam logic [1:0] SIB_AM_NINTH = 2'h0;
  localparam logic [1:0] SIB_AM_SEARCH = 2'h1;
  localparam logic [1:0] SIB_AM_MATCH9 = 2'h2;
  localparam logic [1:0] SIB_AM_BREAK = 2'h3;

  // word length codes and upper-bit fill
  localparam logic [1:0] SIB_WL5 = 2'h0;
  localparam logic [1:0] SIB_WL6 = 2'h1;
  localparam logic [1:0] SIB_WL7 = 2'h2;
  localparam logic [7:0] SIB_FILL5 = 8'hE0;
  localparam logic [7:0] SIB_FILL6 = 8'hC0;
  localparam logic [7:0] SIB_FILL7 = 8'h80;
  localparam logic [7:0] SIB_FILL8 = 8'h00;

  // reset values (chosen; only the mask has a fixed one)
  localparam logic [7:0] SIB_MASK_RESET = 8'h00;
  localparam logic [7:0] SIB_STATUS_RESET = 8'h03;
  localparam logic [7:0] SIB_BYTE_ZERO = 8'h00;
  localparam logic [4:0] SIB_BASE_RESET = 5'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sib_bus_t;

  typedef struct packed {
    logic addr_mode_en;
    logic addr_mode;
    logic nine_bit_en;
    logic parity_en;
    logic even_parity;
    logic [1:0] word_len;
  } sib_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity_bit;
    logic ninth_bit;
    logic stop_ok;
    logic all_low;
  } sib_rxw_t;
endpackage : sib_pkg

// ---- hw/sib_regs.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - vector base bits 7..3 are writable; bit 0 always reads zero.
// - bits 2..1 report the encoded source chosen by hardware.
// - address words compare against compare_value, except in ninth-bit mode where every address word hits; a hit sets address_pending.
// - empty_source_select picks shift-empty (0) or buffer-empty (1) interrupt.
// - receive_block_done set after last receive DMA cycle; software writes 0.
// - transmit_block_done set after last transmit DMA cycle; software clears.
// - error_irq_mask gates overrun, parity and framing interrupts.
// - address_irq_mask and break_irq_mask gate their pending flags.
// - receive data mask gates data and block-done interrupts, never DMA.
// - transmit data mask gates empty and block-done interrupts, never DMA.
// - overrun set when a word loads before the previous one was read.
// - framing_error_flag set when the stop bit is missing.
// - framing error on a monitored address still interrupts and loads word.
// - parity_error_flag set when parity mismatches the selected sense.
// - address_pending set when the selected address condition is seen.
// - break_pending set when the input stays low a whole word.
// - data_pending set each time a word enters receive_buffer.
// - buffer_empty_flag on buffer empty; shift_empty_flag when shifting done.
// - software may clear status flags only; writing 1 leaves a flag.
// - word loads at word end, flags update, short words padded with ones.
// - written byte moves on when the shifter path is free; buffer-empty set.
// - buffer offset reads receive_buffer and writes transmit_buffer.
module sib_regs
  import sib_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire sib_pkg::sib_bus_t bus,
  input wire sib_pkg::sib_cfg_t cfg,
  input wire logic rx_done,
  input wire sib_pkg::sib_rxw_t rx_word,
  input wire logic rx_dma_en,
  input wire logic tx_dma_en,
  input wire logic rx_block_end,
  input wire logic tx_block_end,
  input wire logic tx_ready,
  input wire logic tx_shift_idle,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic rx_dma_req,
  output logic tx_dma_req
);
  import sib_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);

  typedef struct packed {
    logic [4:0] vec_base;
    logic [1:0] enc;
    logic [7:0] compare;
    logic [7:0] mask;
    logic [7:0] status;
    logic [7:0] rx_buf;
    logic rx_unread;
    logic selected;
    logic break_seen;
    logic [7:0] hold;
    logic hold_full;
    logic [DEPTH-1:0][7:0] fifo;
    logic [CW-1:0] count;
    logic idle_prev;
    logic [7:0] rdata;
    logic irq;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic rx_dma_req;
    logic tx_dma_req;
  } sib_state_t;

  sib_state_t s_reg;
  sib_state_t s_next;

  logic [1:0] am_sel;
  logic is_addr_word;
  logic is_match;
  logic addr_hit;
  logic addressed_mode;
  logic load_word;
  logic par_bad;
  logic [7:0] fill;
  logic [7:0] set_vec;
  logic push;
  logic pop;
  logic idle_all;
  logic src_err;
  logic src_brk;
  logic src_rxd;
  logic src_tx;
  logic [CW-1:0] cnt_tmp;

  always_comb
  begin
    s_next = s_reg;
    set_vec = SIB_BYTE_ZERO;
    am_sel = {cfg.addr_mode_en, cfg.addr_mode};
    is_match = (rx_word.data == s_reg.compare);
    is_addr_word = 1'b0;
    addr_hit = 1'b0;
    addressed_mode = 1'b0;
    load_word = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    cnt_tmp = s_reg.count;
    src_err = 1'b0;
    src_brk = 1'b0;
    src_rxd = 1'b0;
    src_tx = 1'b0;

    // parity over the data bits; the ninth bit never counts
    par_bad = ^rx_word.data ^ rx_word.parity_bit ^ ~cfg.even_parity;

    case (cfg.word_len)
      SIB_WL5: fill = SIB_FILL5;
      SIB_WL6: fill = SIB_FILL6;
      SIB_WL7: fill = SIB_FILL7;
      default: fill = SIB_FILL8;
    endcase

    // register writes first so hardware sets below win
    if (bus.wr)
    begin
      case (bus.addr)
        SIB_OFF_VECTOR:
        begin
          s_next.vec_base = bus.wdata[SIB_V_BASE_HI:SIB_V_BASE_LO];
        end
        SIB_OFF_COMPARE:
        begin
          s_next.compare = bus.wdata;
        end
        SIB_OFF_MASK:
        begin
          s_next.mask = bus.wdata;
          s_next.mask[SIB_M_RX_DONE] = s_reg.mask[SIB_M_RX_DONE]
                                       & bus.wdata[SIB_M_RX_DONE];
          s_next.mask[SIB_M_TX_DONE] = s_reg.mask[SIB_M_TX_DONE]
                                       & bus.wdata[SIB_M_TX_DONE];
        end
        SIB_OFF_STATUS:
        begin
          s_next.status = s_reg.status & bus.wdata;
        end
        SIB_OFF_BUFFER:
        begin
          // write side; an unmoved byte is overwritten
          s_next.hold = bus.wdata;
          s_next.hold_full = 1'b1;
        end
        default:
        begin
          s_next.hold_full = s_reg.hold_full;
        end
      endcase
    end

    // read side releases the receive word
    if (bus.rd && bus.addr == SIB_OFF_BUFFER)
    begin
      s_next.rx_unread = 1'b0;
    end

    // received word handling
    if (rx_done)
    begin
      // missing stop bit, break words included
      set_vec[SIB_S_FRM] = ~rx_word.stop_ok;
      if (rx_word.all_low)
      begin
        set_vec[SIB_S_BRK] = 1'b1;
        s_next.break_seen = 1'b1;
      end
      else
      begin
        s_next.break_seen = 1'b0;
        case (am_sel)
          SIB_AM_NINTH:
          begin
            addressed_mode = cfg.nine_bit_en;
            is_addr_word = cfg.nine_bit_en & rx_word.ninth_bit;
            addr_hit = is_addr_word;
          end
          SIB_AM_MATCH9:
          begin
            addressed_mode = 1'b1;
            is_addr_word = rx_word.ninth_bit;
            addr_hit = is_addr_word & is_match;
          end
          SIB_AM_BREAK:
          begin
            addressed_mode = 1'b1;
            is_addr_word = s_reg.break_seen;
            addr_hit = is_addr_word & is_match;
          end
          default:
          begin
            // character search: every word flows, a match flags
            addr_hit = is_match;
          end
        endcase
        if (addressed_mode && is_addr_word)
        begin
          s_next.selected = addr_hit;
        end
        set_vec[SIB_S_ADDR] = addr_hit;
        set_vec[SIB_S_PAR] = cfg.parity_en & par_bad;
        if (!addressed_mode)
        begin
          load_word = 1'b1;
        end
        else if (is_addr_word)
        begin
          load_word = ~rx_word.stop_ok;
        end
        else
        begin
          load_word = s_reg.selected;
        end
      end
    end

    if (load_word)
    begin
      s_next.rx_buf = rx_word.data | fill;
      s_next.rx_unread = 1'b1;
      set_vec[SIB_S_DATA] = 1'b1;
      set_vec[SIB_S_OVR] = s_reg.rx_unread;
    end

    // transmit path: two-entry buffer towards the shifter
    pop = s_reg.tx_valid & tx_ready;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        s_next.fifo[i] = s_reg.fifo[i + 1];
      end
      cnt_tmp = s_reg.count - CNT_ONE;
    end
    push = s_reg.hold_full && (cnt_tmp != CNT_FULL);
    if (push)
    begin
      s_next.fifo[cnt_tmp] = s_reg.hold;
      cnt_tmp = cnt_tmp + CNT_ONE;
      s_next.hold_full = 1'b0;
      set_vec[SIB_S_BEMP] = 1'b1;
    end
    s_next.count = cnt_tmp;

    // shifter idle with nothing queued behind it
    idle_all = tx_shift_idle && (s_reg.count == CNT_ZERO) && !s_reg.hold_full;
    s_next.idle_prev = idle_all;
    set_vec[SIB_S_SEMP] = idle_all & ~s_reg.idle_prev;

    // hardware sets win over a same-cycle clear
    s_next.status = s_next.status | set_vec;
    s_next.mask[SIB_M_RX_DONE] = s_next.mask[SIB_M_RX_DONE] | rx_block_end;
    s_next.mask[SIB_M_TX_DONE] = s_next.mask[SIB_M_TX_DONE] | tx_block_end;

    src_err = (s_next.status[SIB_S_OVR] | s_next.status[SIB_S_FRM]
               | s_next.status[SIB_S_PAR]) & s_next.mask[SIB_M_ERR];
    src_brk = (s_next.status[SIB_S_ADDR] & s_next.mask[SIB_M_ADDR])
              | (s_next.status[SIB_S_BRK] & s_next.mask[SIB_M_BRK]);
    // data pending yields to block end while DMA owns it
    src_rxd = ((s_next.status[SIB_S_DATA] & ~rx_dma_en)
               | s_next.mask[SIB_M_RX_DONE]) & s_next.mask[SIB_M_RXD];
    if (s_next.mask[SIB_M_SRC_SEL])
    begin
      src_tx = s_next.status[SIB_S_BEMP] & ~tx_dma_en;
    end
    else
    begin
      src_tx = s_next.status[SIB_S_SEMP] & ~tx_dma_en;
    end
    src_tx = (src_tx | s_next.mask[SIB_M_TX_DONE]) & s_next.mask[SIB_M_TXD];

    s_next.irq = src_err | src_brk | src_rxd | src_tx;
    // encoded source, receiver ahead of transmitter
    if (src_err)
    begin
      s_next.enc = SIB_ENC_ERR;
    end
    else if (src_brk)
    begin
      s_next.enc = SIB_ENC_BRK;
    end
    else if (src_rxd)
    begin
      s_next.enc = SIB_ENC_RXD;
    end
    else if (src_tx)
    begin
      s_next.enc = SIB_ENC_TX;
    end
    else
    begin
      s_next.enc = s_reg.enc;
    end

    // DMA requests ignore the masks; an error halts receive DMA
    s_next.rx_dma_req = rx_dma_en & s_next.status[SIB_S_DATA]
                        & ~(s_next.status[SIB_S_OVR]
                        | s_next.status[SIB_S_FRM]
                        | s_next.status[SIB_S_PAR]);
    // transmit DMA follows the selected empty event
    s_next.tx_dma_req = tx_dma_en & (s_next.mask[SIB_M_SRC_SEL]
                        ? s_next.status[SIB_S_BEMP]
                        : s_next.status[SIB_S_SEMP]);

    s_next.tx_valid = (s_next.count != CNT_ZERO);
    s_next.tx_byte = s_next.fifo[0];

    // read data is captured one cycle after the strobe
    if (bus.rd)
    begin
      case (bus.addr)
        SIB_OFF_VECTOR:
        begin
          s_next.rdata = {s_reg.vec_base, s_reg.enc, SIB_V_BIT0};
        end
        SIB_OFF_COMPARE: s_next.rdata = s_reg.compare;
        SIB_OFF_MASK: s_next.rdata = s_reg.mask;
        SIB_OFF_STATUS: s_next.rdata = s_reg.status;
        SIB_OFF_BUFFER: s_next.rdata = s_reg.rx_buf;
        default: s_next.rdata = SIB_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.vec_base <= SIB_BASE_RESET;
      s_reg.mask <= SIB_MASK_RESET;
      s_reg.status <= SIB_STATUS_RESET;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign tx_valid = s_reg.tx_valid;
  assign tx_byte = s_reg.tx_byte;
  assign rx_dma_req = s_reg.rx_dma_req;
  assign tx_dma_req = s_reg.tx_dma_req;
endmodule : sib_regs

// ---- verification/sib_regs_checker.sv ----
`timescale 1ns/1ns
module sib_regs_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire sib_pkg::sib_bus_t bus,
  input wire sib_pkg::sib_cfg_t cfg,
  input wire logic rx_done,
  input wire sib_pkg::sib_rxw_t rx_word,
  input wire logic rx_dma_en,
  input wire logic tx_dma_en,
  input wire logic tx_ready,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic rx_dma_req,
  input wire logic tx_dma_req
);
  import sib_pkg::*;
  logic rdv, ld, q;
  logic [7:0] fill;
  assign rdv = ce && bus.rd && !bus.wr;
  // quiet middle cycle, so nothing else touches the flags
  assign q = !bus.wr && !rx_done;
  assign ld = ce && rx_done && !rx_word.all_low &&
    {cfg.addr_mode_en, cfg.addr_mode} == SIB_AM_SEARCH;
  always_comb
  begin
    case (cfg.word_len)
      SIB_WL5: fill = SIB_FILL5;
      SIB_WL6: fill = SIB_FILL6;
      SIB_WL7: fill = SIB_FILL7;
      default: fill = SIB_FILL8;
    endcase
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_vec_zero: assert property (
    rdv && bus.addr == SIB_OFF_VECTOR |=> reg_rdata[0] == SIB_V_BIT0)
    else $error("vector bit 0 set");
  chk_cmp_rw: assert property (
    (ce && bus.wr && bus.addr == SIB_OFF_COMPARE) ##1 q ##1
    (rdv && bus.addr == SIB_OFF_COMPARE) |=> reg_rdata == $past(bus.wdata, 3))
    else $error("compare value lost");
  chk_mask_rw: assert property (
    (ce && bus.wr && bus.addr == SIB_OFF_MASK) ##1 q ##1
    (rdv && bus.addr == SIB_OFF_MASK)
    |=> (reg_rdata & 8'h9F) == ($past(bus.wdata, 3) & 8'h9F))
    else $error("mask bits lost");
  chk_mask_quiet: assert property (
    ce && bus.wr && bus.addr == SIB_OFF_MASK && bus.wdata == 8'h00 |=> !irq)
    else $error("irq with all masks off");
  chk_unmapped: assert property (
    rdv && (bus.addr < SIB_OFF_VECTOR || bus.addr > SIB_OFF_BUFFER)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rx_load: assert property (
    ld ##1 q ##1 (rdv && !rx_done && bus.addr == SIB_OFF_BUFFER)
    |=> reg_rdata == ($past(rx_word.data, 3) | $past(fill, 3)))
    else $error("received word wrong");
  chk_data_flag: assert property (
    ld ##1 q ##1 (rdv && bus.addr == SIB_OFF_STATUS)
    |=> reg_rdata[SIB_S_DATA]) else $error("data flag missing");
  chk_frame_flag: assert property (
    (ce && rx_done && !rx_word.stop_ok) ##1 q ##1
    (rdv && bus.addr == SIB_OFF_STATUS) |=> reg_rdata[SIB_S_FRM])
    else $error("framing flag missing");
  chk_break_flag: assert property (
    (ce && rx_done && rx_word.all_low) ##1 q ##1
    (rdv && bus.addr == SIB_OFF_STATUS) |=> reg_rdata[SIB_S_BRK])
    else $error("break flag missing");
  chk_tx_hold: assert property (
    ce && tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("stalled byte changed");
  chk_rx_dma: assert property (
    $past(ce) && !$past(rx_dma_en) |-> !rx_dma_req)
    else $error("receive dma without enable");
  chk_tx_dma: assert property (
    $past(ce) && !$past(tx_dma_en) |-> !tx_dma_req)
    else $error("transmit dma without enable");
endmodule : sib_regs_checker

// ---- verification/sib_shifter_model.sv ----
`timescale 1ns/1ns
module sib_shifter_model #(
  parameter int SHIFT_CYCLES = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic tx_shift_idle,
  output logic [23:0] log_bytes,
  output logic [7:0] pops
);
  int busy_reg;
  assign tx_ready = busy_reg == 0 && !stall;
  assign tx_shift_idle = busy_reg == 0;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_reg <= 0;
      log_bytes <= '0;
      pops <= '0;
    end
    else if (tx_valid && tx_ready)
    begin
      busy_reg <= SHIFT_CYCLES;
      log_bytes <= {log_bytes[15:0], tx_byte};
      pops <= pops + 8'h01;
    end
    else if (busy_reg != 0)
      busy_reg <= busy_reg - 1;
  end
endmodule : sib_shifter_model

// ---- verification/sib_regs_tb_top.sv ----
`timescale 1ns/1ns
module sib_regs_tb_top;
  import sib_pkg::*;
  logic mclk, rstn, ce, rx_done, rx_dma_en, tx_dma_en, stall;
  logic rx_block_end, tx_block_end, tx_ready, tx_shift_idle;
  logic irq, tx_valid, rx_dma_req, tx_dma_req;
  logic [7:0] reg_rdata, tx_byte, v, pops;
  logic [23:0] log_bytes;
  sib_bus_t bus;
  sib_cfg_t cfg;
  sib_rxw_t rx_word;
  int failures, checks_done;
  logic [7:0] fills [4] = '{SIB_FILL5, SIB_FILL6, SIB_FILL7, SIB_FILL8};
  logic [7:0] masks [5] = '{8'h10, 8'h04, 8'h02, 8'h81, 8'h08};
  logic [1:0] encs [5] = '{SIB_ENC_ERR, SIB_ENC_BRK, SIB_ENC_RXD,
    SIB_ENC_TX, SIB_ENC_BRK};

  sib_regs #(.DEPTH(2)) dut (
    .mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus), .cfg(cfg),
    .rx_done(rx_done), .rx_word(rx_word), .rx_dma_en(rx_dma_en),
    .tx_dma_en(tx_dma_en), .rx_block_end(rx_block_end),
    .tx_block_end(tx_block_end), .tx_ready(tx_ready),
    .tx_shift_idle(tx_shift_idle), .reg_rdata(reg_rdata), .irq(irq),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_dma_req(rx_dma_req),
    .tx_dma_req(tx_dma_req)
  );
  sib_shifter_model far (
    .mclk(mclk), .rstn(rstn), .stall(stall), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_shift_idle(tx_shift_idle),
    .log_bytes(log_bytes), .pops(pops)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  // read data lands one cycle after the strobe edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 v = reg_rdata;
    chk(v & m, e);
  endtask : rdc

  task automatic rx(input logic [7:0] d, input logic stp, input logic brk,
    input logic par);
    @(posedge mclk);
    rx_word <= '{data: d, parity_bit: par, ninth_bit: 1'b0, stop_ok: stp,
      all_low: brk};
    rx_done <= 1'b1;
    @(posedge mclk);
    rx_done <= 1'b0;
    rx_word.data <= ~d;
  endtask : rx

  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial
  begin
    #(50 * 3000);
    failures++;
    summarize();
  end

  initial
  begin
    {rstn, rx_done, rx_dma_en, tx_dma_en, stall} = '0;
    {rx_block_end, tx_block_end, failures, checks_done} = '0;
    ce = 1'b1;
    bus = '0;
    rx_word = '0;
    cfg = '{addr_mode_en: 1'b0, addr_mode: 1'b1, nine_bit_en: 1'b0,
      parity_en: 1'b0, even_parity: 1'b0, word_len: SIB_WL5};
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rdc(SIB_OFF_MASK, 8'hFF, SIB_MASK_RESET);
    rdc(SIB_OFF_STATUS, 8'hFF, SIB_STATUS_RESET);
    rdc(8'hF3, 8'hFF, 8'h00);
    rdc(8'hF9, 8'hFF, 8'h00);
    wr(SIB_OFF_VECTOR, 8'hFF);
    rdc(SIB_OFF_VECTOR, 8'hF9, 8'hF8);
    wr(SIB_OFF_COMPARE, 8'hA5);
    rdc(SIB_OFF_COMPARE, 8'hFF, 8'hA5);
    @(posedge mclk);
    ce <= 1'b0;
    wr(SIB_OFF_COMPARE, 8'h5A);
    ce <= 1'b1;
    rdc(SIB_OFF_COMPARE, 8'hFF, 8'hA5);
    wr(SIB_OFF_MASK, 8'hFF);
    rdc(SIB_OFF_MASK, 8'hFF, 8'h9F);
    wr(SIB_OFF_MASK, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      cfg.word_len <= 2'(i);
      rx(8'h55, 1'b1, 1'b0, 1'b0);
      rdc(SIB_OFF_BUFFER, 8'hFF, 8'h55 | fills[i]);
    end
    wr(SIB_OFF_STATUS, 8'h00);
    rx(8'h12, 1'b1, 1'b0, 1'b0);
    rx(8'h34, 1'b1, 1'b0, 1'b0);
    rdc(SIB_OFF_STATUS, 8'h84, 8'h84);
    rdc(SIB_OFF_BUFFER, 8'hFF, 8'h34);
    wr(SIB_OFF_STATUS, 8'h7F);
    rdc(SIB_OFF_STATUS, 8'h84, 8'h04);
    rx(8'h20, 1'b0, 1'b0, 1'b0);
    rdc(SIB_OFF_STATUS, 8'h40, 8'h40);
    rx(8'h00, 1'b0, 1'b1, 1'b0);
    rdc(SIB_OFF_STATUS, 8'h08, 8'h08);
    rx(8'hA5, 1'b1, 1'b0, 1'b0);
    rdc(SIB_OFF_STATUS, 8'h10, 8'h10);
    wr(SIB_OFF_STATUS, 8'h00);
    @(posedge mclk);
    cfg.parity_en <= 1'b1;
    cfg.even_parity <= 1'b1;
    rx(8'h01, 1'b1, 1'b0, 1'b1);
    rdc(SIB_OFF_STATUS, 8'h20, 8'h00);
    rx(8'h01, 1'b1, 1'b0, 1'b0);
    rdc(SIB_OFF_STATUS, 8'h20, 8'h20);
    @(posedge mclk);
    cfg.parity_en <= 1'b0;
    wr(SIB_OFF_STATUS, 8'h00);
    wr(SIB_OFF_STATUS, 8'hFF);
    rdc(SIB_OFF_STATUS, 8'hFF, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(SIB_OFF_STATUS, 8'h00);
      wr(SIB_OFF_MASK, masks[i]);
      #1 chk({7'h00, irq}, 8'h00);
      case (i)
        0: rx(8'h20, 1'b0, 1'b0, 1'b0);
        1: rx(8'h00, 1'b0, 1'b1, 1'b0);
        2: rx(8'h66, 1'b1, 1'b0, 1'b0);
        3: wr(SIB_OFF_BUFFER, 8'h77);
        default: rx(8'hA5, 1'b1, 1'b0, 1'b0);
      endcase
      @(posedge mclk);
      #1 chk({7'h00, irq}, 8'h01);
      rdc(SIB_OFF_VECTOR, 8'h06, {5'h00, encs[i], 1'b0});
    end
    wr(SIB_OFF_MASK, 8'h00);
    @(posedge mclk);
    stall <= 1'b1;
    wr(SIB_OFF_BUFFER, 8'h11);
    wr(SIB_OFF_BUFFER, 8'h22);
    wr(SIB_OFF_BUFFER, 8'h33);
    rdc(SIB_OFF_BUFFER, 8'hFF, 8'hA5);
    chk(tx_byte, 8'h11);
    chk({7'h00, tx_valid}, 8'h01);
    @(posedge mclk);
    stall <= 1'b0;
    for (int k = 0; k < 60 && pops !== 8'h04; k++)
      @(posedge mclk);
    chk(pops, 8'h04);
    chk(log_bytes[23:16], 8'h11);
    chk(log_bytes[15:8], 8'h22);
    chk(log_bytes[7:0], 8'h33);
    @(posedge mclk);
    {rx_block_end, tx_block_end} <= 2'b11;
    @(posedge mclk);
    {rx_block_end, tx_block_end} <= 2'b00;
    rdc(SIB_OFF_MASK, 8'h60, 8'h60);
    wr(SIB_OFF_MASK, 8'h00);
    rdc(SIB_OFF_MASK, 8'h60, 8'h00);
    @(posedge mclk);
    cfg.addr_mode_en <= 1'b1;
    rx(8'h00, 1'b0, 1'b1, 1'b0);
    rx(8'hC3, 1'b1, 1'b0, 1'b0);
    rx(8'h5A, 1'b1, 1'b0, 1'b0);
    rdc(SIB_OFF_BUFFER, 8'hFF, 8'hA5);
    rx(8'h00, 1'b0, 1'b1, 1'b0);
    rx(8'hA5, 1'b1, 1'b0, 1'b0);
    rx(8'h69, 1'b1, 1'b0, 1'b0);
    rdc(SIB_OFF_BUFFER, 8'hFF, 8'h69);
    rx(8'h00, 1'b0, 1'b1, 1'b0);
    rx(8'h96, 1'b0, 1'b0, 1'b0);
    rdc(SIB_OFF_BUFFER, 8'hFF, 8'h96);
    @(posedge mclk);
    cfg.addr_mode_en <= 1'b0;
    wr(SIB_OFF_STATUS, 8'h00);
    @(posedge mclk);
    {rx_dma_en, tx_dma_en} <= 2'b11;
    rx(8'h3C, 1'b1, 1'b0, 1'b0);
    #1 chk({7'h00, rx_dma_req}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(SIB_OFF_BUFFER, 8'h44);
    repeat (8) @(posedge mclk);
    #1 chk({7'h00, tx_dma_req}, 8'h01);
    summarize();
  end
endmodule : sib_regs_tb_top

bind sib_regs sib_regs_checker chk (
  .mclk(mclk), .rstn(rstn), .ce(ce), .bus(bus), .cfg(cfg),
  .rx_done(rx_done), .rx_word(rx_word), .rx_dma_en(rx_dma_en),
  .tx_dma_en(tx_dma_en), .tx_ready(tx_ready), .reg_rdata(reg_rdata),
  .irq(irq), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req)
);
